// file: shared/scd_defs.svh
// Constants of the system clock distribution block
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH
`define SCD_CLK_PERIOD_NS   10
`define SCD_BUS_OUTS        5
`define SCD_LB_OUTS         3
`define SCD_PERIPHS         7
`define SCD_RCW_SYSTEM_PLL_MULTIPLIER_FIELD_LSB    0
`define SCD_RCW_SYSTEM_PLL_MULTIPLIER_FIELD_W      4
`define SCD_RCW_CORE_LSB    4
`define SCD_RCW_CORE_W      7
`define SCD_RCW_MEM_BIT     11
`define SCD_RCW_LB_BIT      12
`define SCD_HARD_RCW        32'h0000_0024
`define SCD_I2C2_PERIOD     2'h3
`endif

// file: shared/scd_pkg.sv
// Types of the system clock distribution block
package scd_pkg;
  // Peripheral clock ratio selection
  typedef enum logic [1:0] {
    SCD_RATIO_OFF   = 2'h0,
    SCD_RATIO_FULL  = 2'h1,
    SCD_RATIO_HALF  = 2'h2,
    SCD_RATIO_THIRD = 2'h3
  } scd_ratio_t;
  // Local bus divider selection
  typedef enum logic [1:0] {
    SCD_LDIV_2 = 2'h0,
    SCD_LDIV_4 = 2'h1,
    SCD_LDIV_8 = 2'h2,
    SCD_LDIV_R = 2'h3
  } scd_ldiv_t;
endpackage : scd_pkg

// file: src/scd_top.sv
// Clock generation, selection, division and peripheral gating
`include "scd_defs.svh"
module scd_top (
  input  wire logic                                i_clk,
  input  wire logic                                i_sys_rst,
  input  wire logic                                i_host_mode_pin,
  input  wire logic                                i_input_halving_select_pin,
  input  wire logic                                i_host_primary_clock_in,
  input  wire logic                                i_pci_clock_in,
  input  wire logic [`SCD_BUS_OUTS-1:0]            i_output_clock_control_reg,
  input  wire logic [31:0]                         i_reset_config_word_low,
  input  wire logic                                i_hard_coded_cfg_sel,
  input  wire logic [1:0]                          i_local_bus_divider_field,
  input  wire logic [2*`SCD_PERIPHS-1:0]           i_peripheral_clock_ratio_field,
  output logic                                     o_primary_clock,
  output logic                                     o_pci_sync_out,
  output logic [`SCD_BUS_OUTS-1:0]                 o_bus_clock_output_n,
  output logic [1:0]                               o_host_to_sync_ratio,
  output logic                                     o_memory_bus_clock_pair_p,
  output logic                                     o_memory_bus_clock_pair_n,
  output logic                                     o_mem_data_tick,
  output logic [`SCD_LB_OUTS-1:0]                  o_local_bus_clock_out,
  output logic                                     o_core_clock_ref,
  output logic [`SCD_RCW_SYSTEM_PLL_MULTIPLIER_FIELD_W-1:0]               o_system_pll_multiplier_field,
  output logic [`SCD_RCW_CORE_W-1:0]               o_core_pll_multiplier_field,
  output logic [`SCD_PERIPHS-1:0]                  o_periph_clk_tick,
  output logic                                     o_i2c2_clk_tick
);

  // Period in system bus ticks for a ratio; off rechecks every tick
  // Off keeps polling so a unit restarts promptly when enabled
  function automatic logic [1:0] ratio_period(input scd_pkg::scd_ratio_t r);
    case (r)
      scd_pkg::SCD_RATIO_HALF:  ratio_period = 2'h2;
      scd_pkg::SCD_RATIO_THIRD: ratio_period = 2'h3;
      default:                  ratio_period = 2'h1;
    endcase
  endfunction : ratio_period

  // Two-stage synchronisers for every pin-level input
  // No reset here: they must keep sampling while reset is held, so the
  // strap capture right after release sees real pin levels, not zeros
  logic [3:0] sync1_ff;  // First stage, read only by the second
  logic [3:0] sync2_ff;  // Second stage, safe to use
  always_ff @(posedge i_clk) begin
    sync1_ff <= {i_pci_clock_in, i_host_primary_clock_in,
                 i_input_halving_select_pin, i_host_mode_pin};
    sync2_ff <= sync1_ff;
  end

  // Straps and reset config are caught once, just after reset release
  logic                        cap_done_ff;  // Capture has happened
  logic                        host_ff;      // Latched host mode
  logic                        halve_ff;     // Latched halving pin
  logic                        mem_bit_ff;   // Memory clock ratio bit
  logic                        lb_bit_ff;    // Local bus ratio bit
  logic [31:0]                 rcw;          // Selected config word
  assign rcw = i_hard_coded_cfg_sel ? `SCD_HARD_RCW : i_reset_config_word_low;
  // Later changes to straps or word are ignored until the next reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cap_done_ff                   <= 1'b0;
      host_ff                       <= 1'b0;
      halve_ff                      <= 1'b0;
      mem_bit_ff                    <= 1'b0;
      lb_bit_ff                     <= 1'b0;
      o_system_pll_multiplier_field <= '0;
      o_core_pll_multiplier_field   <= '0;
    end else if (!cap_done_ff) begin
      // Core multipliers come from reset config or hard-coded option
      // core multiplier capture
      cap_done_ff                   <= 1'b1;
      host_ff                       <= sync2_ff[0];
      halve_ff                      <= sync2_ff[1];
      mem_bit_ff                    <= rcw[`SCD_RCW_MEM_BIT];
      lb_bit_ff                     <= rcw[`SCD_RCW_LB_BIT];
      o_system_pll_multiplier_field <= rcw[`SCD_RCW_SYSTEM_PLL_MULTIPLIER_FIELD_LSB +: `SCD_RCW_SYSTEM_PLL_MULTIPLIER_FIELD_W];
      o_core_pll_multiplier_field   <= rcw[`SCD_RCW_CORE_LSB +: `SCD_RCW_CORE_W];
    end
  end

  // Tells how much faster the host pin runs than the sync input
  // host-to-sync ratio
  assign o_host_to_sync_ratio = {1'b0, halve_ff} + 2'h1;

  // Primary source selection and edge detect on the synced level
  // primary source select
  logic prim;        // Selected primary clock level
  logic prim_d_ff;   // Previous level for edge detect
  logic prim_ok_ff;  // Source choice has settled for a full cycle
  logic half_ff;     // Primary halved
  // A stopped pin clock simply freezes every derived output
  assign prim = host_ff ? sync2_ff[2] : sync2_ff[3];
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prim_d_ff       <= 1'b0;
      prim_ok_ff      <= 1'b0;
      half_ff         <= 1'b0;
      o_primary_clock <= 1'b0;
    end else begin
      prim_d_ff       <= prim;
      prim_ok_ff      <= cap_done_ff;
      o_primary_clock <= prim;
      // fixed halving divider
      // The mode capture switches the source; skip the step that causes,
      // so a stopped or high pin clock gives no false edge after reset
      if (prim_ok_ff && prim && !prim_d_ff) begin
        half_ff <= ~half_ff;
      end
    end
  end

  // Sync and bus clock outputs exist only in host mode
  // Agent mode parks them low so nothing contends with the shared clock
  // The board must loop the sync output back with matched delay
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pci_sync_out       <= 1'b0;
      o_bus_clock_output_n <= '0;
    end else if (host_ff) begin
      o_pci_sync_out       <= halve_ff ? half_ff : prim;
      o_bus_clock_output_n <= i_output_clock_control_reg & {`SCD_BUS_OUTS{prim}};
    end else begin
      o_pci_sync_out       <= 1'b0;
      o_bus_clock_output_n <= '0;
    end
  end

  // Base phase: one system bus tick every second clock
  logic phase_ff;  // System bus clock level
  logic csb_tick;  // One-cycle system bus tick
  logic ddr_tick;  // Memory controller clock tick
  logic lb_tick;   // Local bus interface clock tick
  // Every rate below is a whole number of these ticks, or of clocks when doubled, so none can drift
  assign csb_tick = phase_ff;
  assign ddr_tick = mem_bit_ff | csb_tick;
  assign lb_tick  = lb_bit_ff | csb_tick;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      phase_ff         <= 1'b0;
      o_core_clock_ref <= 1'b0;
    end else begin
      phase_ff         <= ~phase_ff;
      o_core_clock_ref <= ~phase_ff;
    end
  end

  // Memory bus clock pair is the memory controller clock halved
  // The n leg copies the old p level, so the two legs never agree
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_memory_bus_clock_pair_p <= 1'b0;
      o_memory_bus_clock_pair_n <= 1'b1;
      o_mem_data_tick           <= 1'b0;
    end else begin
      if (ddr_tick) begin
        o_memory_bus_clock_pair_p <= ~o_memory_bus_clock_pair_p;
        o_memory_bus_clock_pair_n <= o_memory_bus_clock_pair_p;
      end
      o_mem_data_tick <= ddr_tick;
    end
  end

  // Local bus divider; the reserved code holds the slowest rate
  // The counter runs freely, so a divider change may cut one period
  logic [2:0] lb_cnt_ff;  // Local bus divider counter
  logic       lb_sel;     // Selected divider output
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lb_cnt_ff <= 3'h0;
    end else if (lb_tick) begin
      lb_cnt_ff <= lb_cnt_ff + 3'h1;
    end
  end
  always_comb begin
    case (scd_pkg::scd_ldiv_t'(i_local_bus_divider_field))
      scd_pkg::SCD_LDIV_2: lb_sel = lb_cnt_ff[0];
      scd_pkg::SCD_LDIV_4: lb_sel = lb_cnt_ff[1];
      default:             lb_sel = lb_cnt_ff[2];
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_local_bus_clock_out <= '0;
    end else begin
      o_local_bus_clock_out <= {`SCD_LB_OUTS{lb_sel}};
    end
  end

  // Peripheral clock gating; ratio changes only at period boundary
  // A new ratio waits for the boundary, so no period is ever shortened
  genvar gi;
  generate
    for (gi = 0; gi < `SCD_PERIPHS; gi++) begin : g_periph
      scd_pkg::scd_ratio_t act_ff;  // Ratio in force
      scd_pkg::scd_ratio_t req;     // Ratio requested by software
      logic [1:0]          cnt_ff;  // Ticks left in current period
      assign req = scd_pkg::scd_ratio_t'(i_peripheral_clock_ratio_field[2*gi +: 2]);
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          act_ff                <= scd_pkg::SCD_RATIO_THIRD;
          cnt_ff                <= 2'h0;
          o_periph_clk_tick[gi] <= 1'b0;
        end else if (csb_tick && cnt_ff == 2'h0) begin
          act_ff                <= req;
          cnt_ff                <= ratio_period(req) - 2'h1;
          o_periph_clk_tick[gi] <= (req != scd_pkg::SCD_RATIO_OFF);
        end else begin
          if (csb_tick) begin
            cnt_ff <= cnt_ff - 2'h1;
          end
          o_periph_clk_tick[gi] <= 1'b0;
        end
      end
      // Off means no ticks at all
      a_off_silent: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        act_ff == scd_pkg::SCD_RATIO_OFF |-> !o_periph_clk_tick[gi])
        else $error("Peripheral ticks while off");
    end
  endgenerate

  // Second I2C clock: fixed third ratio, no control input
  // Shares the bus tick with the units, so the two never drift apart
  logic [1:0] i2c2_cnt_ff;  // Fixed divider counter
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      i2c2_cnt_ff     <= 2'h0;
      o_i2c2_clk_tick <= 1'b0;
    end else if (csb_tick && i2c2_cnt_ff == 2'h0) begin
      i2c2_cnt_ff     <= `SCD_I2C2_PERIOD - 2'h1;
      o_i2c2_clk_tick <= 1'b1;
    end else begin
      if (csb_tick) begin
        i2c2_cnt_ff <= i2c2_cnt_ff - 2'h1;
      end
      o_i2c2_clk_tick <= 1'b0;
    end
  end

  // Checks beside the logic they guard
  // Unit 0 stands in for all units where one unit is named
  a_bus_out_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_output_clock_control_reg[0] |=> !o_bus_clock_output_n[0])
    else $error("Bus clock output driven while disabled");
  a_sync_full: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    host_ff && !halve_ff && cap_done_ff |=> o_pci_sync_out == $past(prim))
    else $error("Sync output not the undivided clock");
  a_ratio_pin: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_host_to_sync_ratio == (halve_ff ? 2'h2 : 2'h1))
    else $error("Host to sync ratio wrong");
  a_mck_toggle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    mem_bit_ff && $past(mem_bit_ff) |-> o_memory_bus_clock_pair_p
      != $past(o_memory_bus_clock_pair_p) && o_memory_bus_clock_pair_n
      == $past(o_memory_bus_clock_pair_p))
    else $error("Memory clock pair not halving");
  a_core_mult_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cap_done_ff && $past(cap_done_ff) |-> $stable(o_core_pll_multiplier_field))
    else $error("Core multiplier changed after capture");
  a_periph_default: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $past(i_sys_rst) |-> g_periph[0].act_ff == scd_pkg::SCD_RATIO_THIRD)
    else $error("Peripheral not at default ratio after reset");
  a_third_spacing: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_periph_clk_tick[0] && g_periph[0].act_ff == scd_pkg::SCD_RATIO_THIRD
      |=> !o_periph_clk_tick[0] [*5])
    else $error("Runt peripheral clock period");
  a_i2c2_fixed: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_i2c2_clk_tick |=> !o_i2c2_clk_tick [*5] ##1 o_i2c2_clk_tick)
    else $error("Second I2C clock not at fixed third");
  a_local_bus_clock_out_same: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_local_bus_clock_out == {`SCD_LB_OUTS{$past(lb_sel)}})
    else $error("Local bus clocks do not follow divider");
  // Agent mode leaves the sync and bus clock pins quiet
  a_agent_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cap_done_ff && !host_ff |=> !o_pci_sync_out && o_bus_clock_output_n == '0)
    else $error("Sync or bus clock driven in agent mode");
  // Doubled memory ratio gives a data beat every cycle
  a_mem_beat: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    mem_bit_ff && $past(mem_bit_ff) |-> o_mem_data_tick)
    else $error("Memory data beat missing at doubled ratio");
  // Core reference follows the system bus clock, one toggle per cycle
  a_core_toggle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cap_done_ff && $past(cap_done_ff) |-> o_core_clock_ref != $past(o_core_clock_ref))
    else $error("Core clock reference not toggling");
  // Doubled local ratio at the half setting toggles every cycle
  a_lb_double: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    lb_bit_ff && $past(lb_bit_ff) && i_local_bus_divider_field == 2'h0
      && $stable(i_local_bus_divider_field)
      |=> o_local_bus_clock_out[0] != $past(o_local_bus_clock_out[0]))
    else $error("Local bus clock not at half the doubled rate");

endmodule : scd_top

// file: tb/scd_clk_src.sv
// Model of the host oscillator and of the shared PCI clock
module scd_clk_src #(
  parameter int HOST_HALF = 3, // Host clock half period, base cycles
  parameter int PCI_HALF  = 4  // PCI clock half period, base cycles
) (
  input  wire logic i_clk,
  input  wire logic i_run,
  output logic      o_host_clk,
  output logic      o_pci_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  int hc = 0; // Host phase count
  int pc = 0; // PCI phase count
  initial begin
    o_host_clk = 1'b1;
    o_pci_clk  = 1'b0;
  end
  always @(negedge i_clk) begin
    if (!i_run) begin
      // Stopped at distinct levels, so a wrong source shows
      o_host_clk <= 1'b1;
      o_pci_clk  <= 1'b0;
      hc <= 0;
      pc <= 0;
    end else begin
      hc <= (hc == HOST_HALF - 1) ? 0 : hc + 1;
      pc <= (pc == PCI_HALF - 1) ? 0 : pc + 1;
      if (hc == HOST_HALF - 1) o_host_clk <= !o_host_clk;
      if (pc == PCI_HALF - 1) o_pci_clk <= !o_pci_clk;
    end
  end
endmodule : scd_clk_src

// file: tb/tb_top.sv
// Self-checking bench of the clock distribution block
`include "scd_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      i_clk     = 1'b0;  // Base clock
  logic                      i_sys_rst = 1'b1;  // Sync reset
  logic                      h_pin     = 1'b1;  // Host mode strap
  logic                      v_pin     = 1'b0;  // Halving strap
  logic                      run       = 1'b0;  // Source running
  logic [`SCD_BUS_OUTS-1:0]  occ       = 5'h0;  // Output enables
  logic [31:0]               rcw       = 32'h0; // Config word
  logic                      hard      = 1'b0;  // Fixed word select
  logic [1:0]                ldiv      = 2'h0;  // Local divider code
  logic [2*`SCD_PERIPHS-1:0] pcr       = 14'h3FFF; // Unit ratios
  logic                      hclk, pclk, prim, sync, mp, mn, mt, core, i2c2;
  logic [`SCD_BUS_OUTS-1:0]  bus;
  logic [1:0]                hsr;
  logic [`SCD_LB_OUTS-1:0]   lb;
  logic [3:0]                smf;
  logic [6:0]                cmf;
  logic [6:0]                tk;
  logic [13:0]               s;                 // Watched events
  logic [13:0]               sp        = 14'h0; // Previous sample
  int                        cnt [14];          // Running counts
  int                        d [14];            // Window counts
  int                        bad = 0;           // Runt or lane faults
  int                        n_errors = 0;
  int                        check_count = 0;
  int                        cyc = 0;
  // Pulse outputs count high cycles, clocks count rising edges
  localparam logic [13:0] PM = 14'h3FC4;
  assign s = {tk, i2c2, core, lb[0], mp, mt, sync, prim};
  initial forever #5 i_clk = ~i_clk;
  scd_clk_src SRC (.i_clk(i_clk), .i_run(run), .o_host_clk(hclk), .o_pci_clk(pclk));
  scd_top DUT (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_host_mode_pin(h_pin),
    .i_input_halving_select_pin(v_pin), .i_host_primary_clock_in(hclk),
    .i_pci_clock_in(pclk), .i_output_clock_control_reg(occ),
    .i_reset_config_word_low(rcw), .i_hard_coded_cfg_sel(hard),
    .i_local_bus_divider_field(ldiv), .i_peripheral_clock_ratio_field(pcr),
    .o_primary_clock(prim), .o_pci_sync_out(sync), .o_bus_clock_output_n(bus),
    .o_host_to_sync_ratio(hsr), .o_memory_bus_clock_pair_p(mp),
    .o_memory_bus_clock_pair_n(mn), .o_mem_data_tick(mt), .o_local_bus_clock_out(lb),
    .o_core_clock_ref(core), .o_system_pll_multiplier_field(smf),
    .o_core_pll_multiplier_field(cmf), .o_periph_clk_tick(tk), .o_i2c2_clk_tick(i2c2));
  // Event monitor; back-to-back unit ticks would be a runt pulse
  always @(negedge i_clk) begin
    for (int b = 0; b < 14; b++) begin
      if (s[b] && (PM[b] || !sp[b])) cnt[b]++;
      if (b > 6 && s[b] && sp[b]) bad++;
    end
    if (!i_sys_rst && (mp === mn || lb !== {3{s[4]}})) bad++;
    sp = s;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp, input int tol);
    logic ok;
    ok = (seen + tol >= exp) && (seen <= exp + tol);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask : chk
  // Settle past a ratio boundary, then count over n cycles
  task automatic meas(input int n);
    int st [14];
    repeat (8) @(negedge i_clk);
    #1 st = cnt;
    repeat (n) @(negedge i_clk);
    #1 foreach (d[b]) d[b] = cnt[b] - st[b];
  endtask : meas
  function automatic int lb_per(input int j, input logic b);
    return (j == 0 ? 2 : j == 1 ? 4 : 8) * (2 - b);
  endfunction : lb_per
  function automatic int tick_exp(input logic [1:0] c);
    return c == 2'h0 ? 0 : 48 / (2 * c);
  endfunction : tick_exp
  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    logic [31:0] w;
    logic        h, v;
    void'($urandom(32'hd8ee));
    for (int k = 0; k < 4; k++) begin
      h = k != 1;
      v = k == 2;
      @(negedge i_clk);
      {h_pin, v_pin, hard, run, pcr, i_sys_rst} = {h, v, k == 3, 1'b0, 14'h3FFF, 1'b1};
      rcw = $urandom;
      rcw[12:11] = (k == 2) ? 2'h3 : (k == 1) ? rcw[12:11] : 2'h0;
      w = hard ? `SCD_HARD_RCW : rcw;
      repeat (6) @(negedge i_clk);
      chk("rst pair", {mp, mn, tk}, 9'h080, 0);
      i_sys_rst = 1'b0;
      repeat (3) @(negedge i_clk);
      chk("ratio", hsr, 1 + v, 0);
      {rcw, v_pin} = ~{rcw, v_pin};
      repeat (5) @(negedge i_clk);
      chk("sys mult", smf, w[3:0], 0);
      chk("core mult", cmf, w[10:4], 0);
      chk("held ratio", hsr, 1 + v, 0);
      chk("prim still", prim, h, 0);
      chk("sync still", sync, h && !v, 0);
      for (int j = 0; j < 4; j++) begin
        occ = (j == 0) ? 5'h1F : 5'($urandom);
        repeat (2) @(negedge i_clk);
        chk("bus out", bus, h ? occ : 5'h0, 0);
      end
      run = 1'b1;
      meas(96);
      chk("prim rate", d[0], h ? 16 : 12, 1);
      chk("sync rate", d[1], h ? 16 / (1 + v) : 0, 1);
      chk("core rate", d[5], 48, 1);
      chk("mem ticks", d[2], 48 * (1 + w[11]), 1);
      chk("mem pair", d[3], 24 * (1 + w[11]), 1);
      for (int j = 0; j < 4; j++) begin
        ldiv = 2'(j);
        meas(128);
        chk("lb rate", d[4], 128 / lb_per(j, w[12]), 1);
      end
      for (int j = 0; j < 4; j++) begin
        // all ratios stay in range here
        if (j > 0) pcr = (j == 1) ? 14'h24E4 : 14'($urandom);
        meas(48);
        for (int u = 0; u < 7; u++) chk("unit ticks", d[7 + u], tick_exp(pcr[2*u +: 2]), 1);
        chk("i2c2 ticks", d[6], 8, 1);
      end
    end
    chk("runt or lane", bad, 0, 0);
    results();
  end
endmodule : tb_top
